/* File: rtl/pulse_train_gen.sv */
// Pulse train generator: period/on-time counter with pulse counting
`default_nettype none
module pulse_train_gen (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Control
  input wire logic run,
  input wire logic [31:0] period,
  input wire logic [31:0] on_cycles,
  input wire logic [31:0] steps,
  // Result
  output logic pulse,
  output logic [31:0] emitted,
  output logic done
);
  typedef struct packed {
    logic [31:0] phase;
    logic [31:0] count;
    logic pulse;
    logic done;
  } state_t;
  state_t s_q, s_d;
  logic cont;

  assign cont = (steps == pulse_cmd_pkg::STEPS_CONT);

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!run) begin
      s_d.phase = '0;
      s_d.count = '0;
      s_d.pulse = 1'b0;
    end else if (!cont && s_q.count >= steps) begin
      s_d.pulse = 1'b0;
    end else begin
      s_d.pulse = (s_q.phase < on_cycles);
      if (s_q.phase + 32'd1 >= period) begin
        s_d.phase = '0;
        if (!cont) begin
          s_d.count = s_q.count + 32'd1;
          s_d.done = (s_q.count + 32'd1 == steps);
        end
      end else begin
        s_d.phase = s_q.phase + 32'd1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pulse = s_q.pulse;
  assign emitted = s_q.count;
  assign done = s_q.done;
endmodule
`default_nettype wire

/* File: rtl/velocity_pulse_command.sv */
// Velocity pulse command block: Wishbone registers, command sequencer and four pulse outputs
// Notes on behaviour
// - When idle, a rising edge of the velocity trigger loads the command and its parameters onto the chosen output; while one is loaded it raises the busy error.
// - A command may take many cycles and ends with exactly one of success or error set.
// - With error set, the read-error trigger latches extended error information for software to read.
// - An output selector picks which of the four pulse outputs is driven.
// - The pulse rate is accepted from 20 Hz to 25 kHz, or to 65535 Hz (the top of the 16-bit rate field) on the enhanced variant.
// - A 32-bit step count sets how many pulses the chosen output emits.
// - A step count of all ones runs the output continuously.
// - A rising edge of the save trigger copies the edited preset table into flash.
`default_nettype none
module velocity_pulse_command #(
  parameter int NUM_OUTPUTS = 4,
  parameter bit ENHANCED = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Flash write port for the preset table
  output logic flash_req,
  input wire logic flash_done,
  input wire logic flash_fail,
  // Pulse outputs
  output logic [NUM_OUTPUTS-1:0] pulse_out,
  output logic [NUM_OUTPUTS-1:0] dir_out,
  // Interrupt
  output logic irq
);
  // The output selector is two bits wide, so only four outputs can be served
  if (NUM_OUTPUTS != 4) begin : g_bad_outputs
    $error("NUM_OUTPUTS must be 4");
  end

  localparam int IRQ_W_L = pulse_cmd_pkg::IRQ_W;

  typedef enum logic [2:0] {IDLE, CHECK, LOADED, SAVING} phase_t;

  typedef struct packed {
    phase_t phase;
    logic [4:0] ctrl;
    logic [1:0] out_sel;
    logic [15:0] freq;
    logic [7:0] duty;
    logic [31:0] steps;
    logic success;
    logic error;
    logic [7:0] err_code;
    logic [7:0] err_info;
    logic [IRQ_W_L-1:0] irq_stat;
    logic [IRQ_W_L-1:0] irq_mask;
    logic [1:0] act_sel;
    logic [31:0] period;
    logic [31:0] on_cyc;
    logic [31:0] act_steps;
    logic [15:0] flash_cnt;
    logic [31:0] rdata;
    logic ack;
  } state_t;

  state_t s_q, s_d;
  logic wr, rd_ack_cycle;
  logic [31:0] wmask;
  logic velo_rise, save_rise, rderr_rise;
  logic run;
  logic gen_pulse, gen_done;
  logic [31:0] emitted;
  logic [31:0] max_hz;
  logic [IRQ_W_L-1:0] ev;
  logic [7:0] duty_eff;

  assign max_hz = ENHANCED ? 32'(pulse_cmd_pkg::FREQ_MAX_ENH_HZ) : 32'(pulse_cmd_pkg::FREQ_MAX_BASIC_HZ);
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.ack;
  assign rd_ack_cycle = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign run = (s_q.phase == LOADED) && s_q.ctrl[pulse_cmd_pkg::CTRL_EN_BIT];
  assign duty_eff = (s_q.duty == 8'h00) ? 8'(pulse_cmd_pkg::DUTY_DEFAULT) : s_q.duty;

  always_comb begin
    s_d = s_q;
    ev = '0;
    velo_rise = 1'b0;
    save_rise = 1'b0;
    rderr_rise = 1'b0;
    s_d.ack = rd_ack_cycle;
    // Register writes
    if (wr) begin
      if (wb_adr_i == pulse_cmd_pkg::CTRL_OFS) begin
        // Triggers only count when the control byte lane is really written
        if (wb_sel_i[0]) begin
          velo_rise = wb_dat_i[pulse_cmd_pkg::CTRL_VELO_BIT] && !s_q.ctrl[pulse_cmd_pkg::CTRL_VELO_BIT];
          save_rise = wb_dat_i[pulse_cmd_pkg::CTRL_SAVE_BIT] && !s_q.ctrl[pulse_cmd_pkg::CTRL_SAVE_BIT];
          rderr_rise = wb_dat_i[pulse_cmd_pkg::CTRL_RDERR_BIT] && !s_q.ctrl[pulse_cmd_pkg::CTRL_RDERR_BIT];
          s_d.ctrl = wb_dat_i[4:0];
        end
      end else if (wb_adr_i == pulse_cmd_pkg::OUT_SEL_OFS) begin
        if (wb_sel_i[0]) s_d.out_sel = wb_dat_i[1:0];
      end else if (wb_adr_i == pulse_cmd_pkg::FREQ_OFS) begin
        s_d.freq = (s_q.freq & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end else if (wb_adr_i == pulse_cmd_pkg::DUTY_OFS) begin
        if (wb_sel_i[0]) s_d.duty = wb_dat_i[7:0];
      end else if (wb_adr_i == pulse_cmd_pkg::STEPS_OFS) begin
        s_d.steps = (s_q.steps & ~wmask) | (wb_dat_i & wmask);
      end else if (wb_adr_i == pulse_cmd_pkg::IRQ_MASK_OFS) begin
        if (wb_sel_i[0]) s_d.irq_mask = wb_dat_i[IRQ_W_L-1:0];
      end
    end
    // Command sequencer
    case (s_q.phase)
      IDLE: begin
        if (velo_rise) begin
          s_d.success = 1'b0;
          s_d.error = 1'b0;
          s_d.phase = CHECK;
        end else if (save_rise) begin
          s_d.success = 1'b0;
          s_d.error = 1'b0;
          s_d.flash_cnt = '0;
          s_d.phase = SAVING;
        end
      end
      CHECK: begin
        if (32'(s_q.freq) < 32'(pulse_cmd_pkg::FREQ_MIN_HZ) || 32'(s_q.freq) > max_hz) begin
          s_d.error = 1'b1;
          s_d.err_code = pulse_cmd_pkg::ERR_FREQ;
          ev[pulse_cmd_pkg::IRQ_ERR_BIT] = 1'b1;
          s_d.phase = IDLE;
        end else if (32'(s_q.duty) > 32'(pulse_cmd_pkg::DUTY_MAX)) begin
          s_d.error = 1'b1;
          s_d.err_code = pulse_cmd_pkg::ERR_DUTY;
          ev[pulse_cmd_pkg::IRQ_ERR_BIT] = 1'b1;
          s_d.phase = IDLE;
        end else begin
          s_d.act_sel = s_q.out_sel;
          s_d.period = 32'(pulse_cmd_pkg::CLK_HZ) / 32'(s_q.freq);
          s_d.on_cyc = (32'(pulse_cmd_pkg::CLK_HZ) / 32'(s_q.freq)) * 32'(duty_eff) / 32'd100;
          s_d.act_steps = s_q.steps;
          s_d.success = 1'b1;
          s_d.err_code = pulse_cmd_pkg::ERR_NONE;
          ev[pulse_cmd_pkg::IRQ_DONE_BIT] = 1'b1;
          s_d.phase = LOADED;
        end
      end
      LOADED: begin
        if (gen_done) ev[pulse_cmd_pkg::IRQ_TRAIN_BIT] = 1'b1;
        if (velo_rise) begin
          s_d.success = 1'b0;
          s_d.error = 1'b1;
          s_d.err_code = pulse_cmd_pkg::ERR_BUSY;
          ev[pulse_cmd_pkg::IRQ_ERR_BIT] = 1'b1;
        end else if (s_q.ctrl[pulse_cmd_pkg::CTRL_EN_BIT] && !s_d.ctrl[pulse_cmd_pkg::CTRL_EN_BIT]) begin
          // Clearing enable retires the loaded command so a new one can be taken
          s_d.phase = IDLE;
        end else if (!s_q.ctrl[pulse_cmd_pkg::CTRL_EN_BIT] && save_rise) begin
          s_d.success = 1'b0;
          s_d.error = 1'b0;
          s_d.flash_cnt = '0;
          s_d.phase = SAVING;
        end
      end
      SAVING: begin
        s_d.flash_cnt = s_q.flash_cnt + 16'd1;
        if (flash_fail) begin
          s_d.error = 1'b1;
          s_d.err_code = pulse_cmd_pkg::ERR_FLASH;
          ev[pulse_cmd_pkg::IRQ_ERR_BIT] = 1'b1;
          s_d.phase = IDLE;
        end else if (flash_done && 32'(s_q.flash_cnt) >= 32'(pulse_cmd_pkg::FLASH_WRITE_CYCLES)) begin
          s_d.success = 1'b1;
          ev[pulse_cmd_pkg::IRQ_SAVE_BIT] = 1'b1;
          s_d.phase = IDLE;
        end
      end
      default: s_d.phase = IDLE;
    endcase
    if (rderr_rise && s_q.error) begin
      s_d.err_info = s_q.err_code;
    end
    // Sticky interrupt status: write one clears, a new event wins
    if (wr && wb_adr_i == pulse_cmd_pkg::IRQ_STAT_OFS && wb_sel_i[0]) begin
      s_d.irq_stat = s_q.irq_stat & ~wb_dat_i[IRQ_W_L-1:0];
    end
    s_d.irq_stat = s_d.irq_stat | ev;
    // Read data
    s_d.rdata = 32'h0000_0000;
    if (wb_adr_i == pulse_cmd_pkg::CTRL_OFS) begin
      s_d.rdata = 32'(s_q.ctrl);
    end else if (wb_adr_i == pulse_cmd_pkg::OUT_SEL_OFS) begin
      s_d.rdata = 32'(s_q.out_sel);
    end else if (wb_adr_i == pulse_cmd_pkg::FREQ_OFS) begin
      s_d.rdata = 32'(s_q.freq);
    end else if (wb_adr_i == pulse_cmd_pkg::DUTY_OFS) begin
      s_d.rdata = 32'(s_q.duty);
    end else if (wb_adr_i == pulse_cmd_pkg::STEPS_OFS) begin
      s_d.rdata = s_q.steps;
    end else if (wb_adr_i == pulse_cmd_pkg::STATUS_OFS) begin
      s_d.rdata = {28'h000_0000, run, (s_q.phase == CHECK || s_q.phase == SAVING), s_q.error, s_q.success};
    end else if (wb_adr_i == pulse_cmd_pkg::IRQ_STAT_OFS) begin
      s_d.rdata = 32'(s_q.irq_stat);
    end else if (wb_adr_i == pulse_cmd_pkg::IRQ_MASK_OFS) begin
      s_d.rdata = 32'(s_q.irq_mask);
    end else if (wb_adr_i == pulse_cmd_pkg::ERR_INFO_OFS) begin
      s_d.rdata = 32'(s_q.err_info);
    end else if (wb_adr_i == pulse_cmd_pkg::EMITTED_OFS) begin
      s_d.rdata = emitted;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.phase <= IDLE;
      s_q.freq <= pulse_cmd_pkg::FREQ_RST;
      s_q.duty <= pulse_cmd_pkg::DUTY_RST;
      s_q.steps <= pulse_cmd_pkg::STEPS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  pulse_train_gen u_gen (
    .clock(clock),
    .rstn(rstn),
    .run(run),
    .period(s_q.period),
    .on_cycles(s_q.on_cyc),
    .steps(s_q.act_steps),
    .pulse(gen_pulse),
    .emitted(emitted),
    .done(gen_done)
  );

  always_comb begin
    pulse_out = '0;
    dir_out = '0;
    pulse_out[s_q.act_sel] = gen_pulse;
    dir_out[s_q.act_sel] = s_q.ctrl[pulse_cmd_pkg::CTRL_DIR_BIT] && (s_q.phase == LOADED);
  end

  assign flash_req = (s_q.phase == SAVING);
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdata;
  assign irq = |(s_q.irq_stat & s_q.irq_mask);
endmodule
`default_nettype wire

/* File: shared/pulse_cmd_pkg.sv */
// Package: register map, field layout, reset values and timing for the velocity pulse command block
`default_nettype none
package pulse_cmd_pkg;
  // Register byte offsets (one aligned 32-bit word each)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] OUT_SEL_OFS = 8'h04;
  localparam logic [7:0] FREQ_OFS = 8'h08;
  localparam logic [7:0] DUTY_OFS = 8'h0C;
  localparam logic [7:0] STEPS_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h1C;
  localparam logic [7:0] ERR_INFO_OFS = 8'h20;
  localparam logic [7:0] EMITTED_OFS = 8'h24;
  // Control register bit positions
  localparam int CTRL_VELO_BIT = 0;
  localparam int CTRL_SAVE_BIT = 1;
  localparam int CTRL_RDERR_BIT = 2;
  localparam int CTRL_DIR_BIT = 3;
  localparam int CTRL_EN_BIT = 4;
  // Status register bit positions
  localparam int ST_SUCCESS_BIT = 0;
  localparam int ST_ERROR_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_RUN_BIT = 3;
  // Interrupt status bit positions
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam int IRQ_TRAIN_BIT = 2;
  localparam int IRQ_SAVE_BIT = 3;
  localparam int IRQ_W = 4;
  // Error codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_FREQ = 8'h01;
  localparam logic [7:0] ERR_DUTY = 8'h02;
  localparam logic [7:0] ERR_BUSY = 8'h03;
  localparam logic [7:0] ERR_FLASH = 8'h04;
  // Reset values and the continuous-run step count
  localparam logic [15:0] FREQ_RST = 16'h03E8;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [31:0] STEPS_RST = 32'h0000_0000;
  localparam logic [31:0] STEPS_CONT = 32'hFFFF_FFFF;
  // Frequency limits in Hz, clock rate, and duty cycle default and maximum
  localparam int FREQ_MIN_HZ = 20;
  localparam int FREQ_MAX_BASIC_HZ = 25000;
  localparam int FREQ_MAX_ENH_HZ = 250000;
  localparam int CLK_HZ = 100_000_000;
  localparam int DUTY_DEFAULT = 50;
  localparam int DUTY_MAX = 99;
  // Minimum cycles spent writing the preset table to flash before its done answer is taken; a fail answer is taken at once
  localparam int FLASH_WRITE_CYCLES = 64;
endpackage
`default_nettype wire

/* File: tb/flash_model.sv */
// Behavioural flash that answers a write request with done, or fail in fail mode, after a delay
`default_nettype none
module flash_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Flash port and fault control
  input wire logic flash_req,
  input wire logic fail_mode,
  input wire logic slow,
  output logic flash_done,
  output logic flash_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] cnt;
  } flash_t;
  flash_t st_q;
  flash_t st_d;
  logic ready;
  always_comb begin
    st_d.cnt = flash_req ? st_q.cnt + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  // Answer stands only while the request is held
  assign ready = flash_req && (st_q.cnt >= (slow ? 16'h00C8 : 16'h0050));
  assign flash_done = ready && !fail_mode;
  assign flash_fail = ready && fail_mode;
endmodule
`default_nettype wire

/* File: tb/velocity_pulse_command_tb.sv */
// Self-checking bench for the velocity pulse command block
`default_nettype none
module velocity_pulse_command_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTRL = pulse_cmd_pkg::CTRL_OFS;
  localparam logic [7:0] STAT = pulse_cmd_pkg::STATUS_OFS;
  localparam logic [7:0] ISTAT = pulse_cmd_pkg::IRQ_STAT_OFS;
  localparam logic [7:0] MASK = pulse_cmd_pkg::IRQ_MASK_OFS;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, noted = 1'b0, prev = 1'b0, fail_mode = 1'b0, slow = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000, seed = 32'h0000_9414, wb_dat_o;
  logic [3:0] wb_sel_i = 4'hF, pulse_out, dir_out;
  logic wb_ack_o, flash_req, flash_done, flash_fail, irq;
  logic [1:0] sel = 2'b00;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  int n_mismatch = 0, checks = 0, hi_cnt = 0, rise_cnt = 0, n;
  int duty[3] = '{0, 50, 25};
  int bad[3][3] = '{'{19, 0, pulse_cmd_pkg::ERR_FREQ}, '{25001, 0, pulse_cmd_pkg::ERR_FREQ},
    '{1000, 100, pulse_cmd_pkg::ERR_DUTY}};
  initial forever #5 clock = ~clock;
  velocity_pulse_command #(.NUM_OUTPUTS(4), .ENHANCED(1'b0)) u_dut (.clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_req(flash_req), .flash_done(flash_done),
    .flash_fail(flash_fail), .pulse_out(pulse_out), .dir_out(dir_out), .irq(irq));
  flash_model u_flash (.clock(clock), .rstn(rstn), .flash_req(flash_req), .fail_mode(fail_mode), .slow(slow),
    .flash_done(flash_done), .flash_fail(flash_fail));
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (exp_q.size() != 0) n_mismatch++;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // A nonzero mask makes the transfer a checked read
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [31:0] mask = '0);
    int k;
    k = 0;
    if (mask != '0) exp_q.push_back({mask, dat});
    @(posedge clock);
    noted <= (mask != '0);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clock);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k == 20) n_mismatch++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    noted <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic load(input int f, input int d, input logic [31:0] st);
    wb(1'b1, pulse_cmd_pkg::FREQ_OFS, 32'(f));
    wb(1'b1, pulse_cmd_pkg::DUTY_OFS, 32'(d));
    wb(1'b1, pulse_cmd_pkg::STEPS_OFS, st);
    wb(1'b1, pulse_cmd_pkg::OUT_SEL_OFS, 32'(sel));
    wb(1'b1, CTRL, 32'h0000_0000);
    wb(1'b1, CTRL, 32'h0000_0001);
  endtask
  task automatic errchk(input logic [7:0] code);
    wb(1'b0, STAT, 32'h0000_0002, 32'h0000_0003);
    wb(1'b1, CTRL, 32'h0000_0004);
    wb(1'b0, pulse_cmd_pkg::ERR_INFO_OFS, 32'(code), 32'h0000_00FF);
  endtask
  always @(posedge clock) begin
    if (noted && wb_ack_o === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check("read data", wb_dat_o & e[63:32], e[31:0]);
    end
    prev <= pulse_out[sel];
    if (pulse_out[sel] === 1'b1) hi_cnt++;
    if (pulse_out[sel] === 1'b1 && prev === 1'b0) rise_cnt++;
  end
  initial begin
    repeat (90000) @(posedge clock);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    wb(1'b0, pulse_cmd_pkg::FREQ_OFS, 32'(pulse_cmd_pkg::FREQ_RST), 32'h0000_FFFF);
    wb(1'b0, pulse_cmd_pkg::STEPS_OFS, pulse_cmd_pkg::STEPS_RST, 32'hFFFF_FFFF);
    wb(1'b0, STAT, 32'h0000_0000, 32'hFFFF_FFFF);
    wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h3C, 32'h0000_0000, 32'hFFFF_FFFF);
    wb(1'b1, MASK, 32'h0000_000F);
    for (int i = 0; i < 3; i++) begin
      load(bad[i][0], bad[i][1], 32'h0000_0005);
      errchk(8'(bad[i][2]));
      check("irq raised", 32'(irq), 32'h0000_0001);
      wb(1'b1, MASK, 32'h0000_0000);
      check("irq masked", 32'(irq), 32'h0000_0000);
      wb(1'b1, MASK, 32'h0000_000F);
      wb(1'b1, ISTAT, 32'h0000_000F);
      check("irq cleared", 32'(irq), 32'h0000_0000);
    end
    for (int i = 0; i < 4; i++) begin
      sel = 2'(xorshift());
      load(25000, i < 3 ? duty[i] : 0, i < 3 ? 32'h0000_0002 : pulse_cmd_pkg::STEPS_CONT);
      wb(1'b0, STAT, 32'h0000_0001, 32'h0000_0003);
      if (i == 0) begin
        wb(1'b1, CTRL, 32'h0000_0000);
        wb(1'b1, CTRL, 32'h0000_0001);
        errchk(pulse_cmd_pkg::ERR_BUSY);
      end
      wb(1'b1, ISTAT, 32'h0000_000F);
      hi_cnt = 0;
      rise_cnt = 0;
      wb(1'b1, CTRL, 32'h0000_0018);
      check("direction", 32'(dir_out), 32'h0000_0001 << sel);
      if (i == 3) begin
        repeat (20000) @(posedge clock);
        check("endless train", 32'(rise_cnt > 3), 32'h0000_0001);
        wb(1'b0, STAT, 32'h0000_0008, 32'h0000_0008);
      end else begin
        n = 0;
        while (irq !== 1'b1 && n < 20000) begin
          @(posedge clock);
          n++;
        end
        repeat (50) @(posedge clock);
        check("pulses", 32'(rise_cnt), 32'h0000_0002);
        check("on time", 32'(hi_cnt), 32'(2 * pulse_cmd_pkg::CLK_HZ / 25000 *
          (duty[i] == 0 ? pulse_cmd_pkg::DUTY_DEFAULT : duty[i]) / 100));
        wb(1'b0, pulse_cmd_pkg::EMITTED_OFS, 32'h0000_0002, 32'hFFFF_FFFF);
        wb(1'b0, ISTAT, 32'h0000_0004, 32'h0000_0004);
      end
      wb(1'b1, CTRL, 32'h0000_0000);
    end
    for (int f = 0; f < 2; f++) begin
      fail_mode <= (f == 1);
      slow <= (f == 1);
      wb(1'b1, CTRL, 32'h0000_0002);
      wb(1'b0, STAT, 32'h0000_0004, 32'h0000_0004);
      n = 0;
      while ((n < 5 || flash_req === 1'b1) && n < 400) begin
        @(posedge clock);
        n++;
      end
      wb(1'b0, STAT, f == 1 ? 32'h0000_0002 : 32'h0000_0001, 32'h0000_0003);
      if (f == 1) errchk(pulse_cmd_pkg::ERR_FLASH);
      else wb(1'b0, ISTAT, 32'h0000_0008, 32'h0000_0008);
      wb(1'b1, CTRL, 32'h0000_0000);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire

/* File: tb/vpc_asserts.sv */
// Port assertions for the velocity pulse command block
`default_nettype none
module vpc_asserts #(
  parameter int NUM_OUTPUTS = 4,
  parameter bit ENHANCED = 1'b0
) (
  // Clock, reset and bus
  input wire logic clock,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Flash and pulses
  input wire logic flash_req,
  input wire logic flash_done,
  input wire logic flash_fail,
  input wire logic [NUM_OUTPUTS-1:0] pulse_out,
  input wire logic [NUM_OUTPUTS-1:0] dir_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MIN_GAP = pulse_cmd_pkg::CLK_HZ /
    (ENHANCED ? pulse_cmd_pkg::FREQ_MAX_ENH_HZ : pulse_cmd_pkg::FREQ_MAX_BASIC_HZ);
  typedef struct packed {
    logic [31:0] gap;
    logic [31:0] fcnt;
    logic prev;
  } chk_t;
  chk_t st_q;
  chk_t st_d;
  // Cycles since the last pulse edge, and length of the flash request
  always_comb begin
    st_d = st_q;
    st_d.prev = |pulse_out;
    st_d.fcnt = flash_req ? st_q.fcnt + 32'h0000_0001 : 32'h0000_0000;
    st_d.gap = (st_d.prev && !st_q.prev) ? 32'h0000_0001 : st_q.gap + {31'h0000_0000, ~&st_q.gap};
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q <= {32'hFFFF_FFFF, 32'h0000_0000, 1'b0};
    end else begin
      st_q <= st_d;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_stat_rd;
    wb_ack_o && !wb_we_i && wb_adr_i == pulse_cmd_pkg::STATUS_OFS;
  endsequence
  sequence s_flash_end;
    flash_req && (flash_done || flash_fail) && st_q.fcnt >= 32'(pulse_cmd_pkg::FLASH_WRITE_CYCLES);
  endsequence
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_ack_answer;
    s_req |=> wb_ack_o;
  endproperty
  property p_pulse_one;
    $onehot0(pulse_out);
  endproperty
  property p_dir_one;
    $onehot0(dir_out);
  endproperty
  property p_status_excl;
    s_stat_rd |-> !(wb_dat_o[pulse_cmd_pkg::ST_SUCCESS_BIT] && wb_dat_o[pulse_cmd_pkg::ST_ERROR_BIT]);
  endproperty
  property p_pulse_gap;
    (|pulse_out) && !st_q.prev |-> st_q.gap >= MIN_GAP;
  endproperty
  property p_flash_min;
    $fell(flash_req) |-> st_q.fcnt >= pulse_cmd_pkg::FLASH_WRITE_CYCLES;
  endproperty
  property p_flash_end;
    s_flash_end |-> ##[1:3] !flash_req;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered next cycle");
  a_pulse_one: assert property (p_pulse_one) else $error("more than one pulse output active");
  a_dir_one: assert property (p_dir_one) else $error("more than one direction output active");
  a_status_excl: assert property (p_status_excl) else $error("success and error both set");
  a_pulse_gap: assert property (p_pulse_gap) else $error("pulse rate above the limit");
  a_flash_min: assert property (p_flash_min) else $error("flash write ended too early");
  a_flash_end: assert property (p_flash_end) else $error("flash request not released");
endmodule
bind velocity_pulse_command vpc_asserts #(.NUM_OUTPUTS(NUM_OUTPUTS), .ENHANCED(ENHANCED)) u_asserts (
  .clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_req(flash_req), .flash_done(flash_done),
  .flash_fail(flash_fail), .pulse_out(pulse_out), .dir_out(dir_out));
`default_nettype wire
